// file: src/mbs_handler.sv
// Behaviour
// - Function 06 writes exactly one holding register at the zero-based query address.
// - Function 06 query: address hi, lo, value hi, lo, then CRC.
// - Function 06 answer echoes the query, sent only after the register took the value.
// - Function 08 query carries a two-byte sub-function code choosing the test.
// - Diagnostic answer repeats function code and both sub-function bytes.
// - Diagnostic data field is two bytes; some tests return results there.
// - Sub-function 0000 returns the query data unchanged: whole answer equals query.
// - Function 0F forces at most 256 relays per query.
// - Relay references are zero-based; first relay is number zero.
// - Each forced relay turns on for data bit one, off for zero.
// - Bit zero of first data byte is the start relay, later bits climb upward.
// - Function 0F query: start hi, lo, quantity hi, lo, byte count, data, CRC.
// - Function 0F answer: address, function, start, quantity, CRC, no data bytes.
// - Exception answer sets function code top bit and carries an exception code.
// - Sixteen-bit values other than the CRC travel high byte first, low byte second; the CRC goes low byte first.
package mbs_pkg;
  localparam logic [7:0]  FN_PRESET_ONE  = 8'h06;
  localparam logic [7:0]  FN_DIAG        = 8'h08;
  localparam logic [7:0]  FN_FORCE_MULTI = 8'h0f;
  localparam logic [15:0] SUB_ECHO       = 16'h0000;
  localparam logic [7:0]  EXC_FLAG       = 8'h80;
  localparam logic [7:0]  EXC_NONE       = 8'h00;
  localparam logic [7:0]  EXC_FUNCTION   = 8'h01;
  localparam logic [7:0]  EXC_ADDRESS    = 8'h02;
  localparam logic [7:0]  EXC_VALUE      = 8'h03;
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam logic [15:0] CRC_POLY       = 16'ha001;
  localparam int          FIXED_LEN      = 8;
  localparam int          FORCE_HDR_LEN  = 9;
  localparam int          NORMAL_RSP_LEN = 6;
  localparam int          EXC_RSP_LEN    = 3;
  localparam int          FORCE_DATA_POS = 7;
  localparam int          MIN_FRAME      = 4;

  typedef enum logic [2:0] {
    S_RX    = 3'b000,
    S_CHECK = 3'b001,
    S_EXEC  = 3'b011,
    S_SEND  = 3'b010,
    S_CRCL  = 3'b110,
    S_CRCH  = 3'b111
  } mbs_state_t;

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

`timescale 1ns/10ps
module mbs_handler #(
  parameter int REG_COUNT  = 16,
  parameter int NUM_RELAYS = 256,
  parameter int MAX_FRAME  = 48,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                    ref_clk,    // 125 MHz clock
  input  wire logic                    nrst,       // Asynchronous reset, active low
  input  wire logic [7:0]              ownAddr,    // Server address of this device
  input  wire logic                    rxValid,    // Received byte strobe
  input  wire logic [7:0]              rxData,     // Received byte
  input  wire logic                    rxEnd,      // Frame end pulse (with or after last byte)
  output logic                         rxReady,    // Accepting query bytes
  output logic                         txValid,    // Response byte available
  output logic [7:0]                   txData,     // Response byte
  input  wire logic                    txReady,    // Link takes response byte
  output logic [NUM_RELAYS-1:0]        relayState, // Relay outputs, 1 = on
  output logic [REG_COUNT*16-1:0]      holdRegs    // Holding registers, reg 0 in low bits
);
  localparam int CW = $clog2(MAX_FRAME + 1);

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]            frameBuf [MAX_FRAME];
  logic [CW-1:0]         rxCnt_reg;
  logic [15:0]           rxCrc_reg;
  logic                  overflow_reg;
  mbs_pkg::mbs_state_t   state_reg;
  mbs_pkg::mbs_state_t   state_next;
  logic [7:0]            excCode_reg;
  logic [7:0]            excCode_next;
  logic [CW-1:0]         respLen_reg;
  logic [CW-1:0]         txIdx_reg;
  logic [15:0]           txCrc_reg;
  logic                  rxReady_reg;
  logic [NUM_RELAYS-1:0] relayState_reg;
  logic [15:0]           holdReg_reg [REG_COUNT];

  logic [7:0]  fnCode;
  logic [15:0] fieldA;
  logic [15:0] fieldB;
  logic [7:0]  byteCount;
  logic [16:0] neededBytes;
  logic [16:0] relayEnd;
  logic        frameOk;
  logic        pushValid;
  logic [7:0]  pushData;
  logic        pushReady;
  logic        pushTake;

  // Field decode shared by all functions (high byte first)
  assign fnCode      = frameBuf[1];
  assign fieldA      = {frameBuf[2], frameBuf[3]};
  assign fieldB      = {frameBuf[4], frameBuf[5]};
  assign byteCount   = frameBuf[6];
  assign neededBytes = (17'(fieldB) + 17'd7) >> 3;
  assign relayEnd    = 17'(fieldA) + 17'(fieldB);

  // Damaged, truncated or foreign queries are dropped without an answer
  assign frameOk = !overflow_reg && (rxCnt_reg >= CW'(mbs_pkg::MIN_FRAME))
                   && (rxCrc_reg == 16'h0000) && (frameBuf[0] == ownAddr);

  ////////////////////////////////////////////////////////////////////////
  // Query reception; bytes are refused while a query is being served
  always_ff @(posedge ref_clk) begin
    if (state_reg == mbs_pkg::S_RX && rxValid && rxCnt_reg < CW'(MAX_FRAME)) begin
      frameBuf[rxCnt_reg] <= rxData;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxCnt_reg    <= '0;
      rxCrc_reg    <= mbs_pkg::CRC_INIT;
      overflow_reg <= 1'b0;
    end else if (state_reg == mbs_pkg::S_CHECK) begin
      rxCnt_reg    <= '0;
      rxCrc_reg    <= mbs_pkg::CRC_INIT;
      overflow_reg <= 1'b0;
    end else if (state_reg == mbs_pkg::S_RX && rxValid) begin
      rxCrc_reg <= mbs_pkg::crcStep(rxCrc_reg, rxData);
      if (rxCnt_reg < CW'(MAX_FRAME)) begin
        rxCnt_reg <= rxCnt_reg + 1'b1;
      end else begin
        overflow_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Validation of the query layout and ranges
  always_comb begin
    excCode_next = mbs_pkg::EXC_NONE;
    case (fnCode)
      mbs_pkg::FN_PRESET_ONE: begin
        if (rxCnt_reg != CW'(mbs_pkg::FIXED_LEN)) begin
          excCode_next = mbs_pkg::EXC_VALUE;
        end else if (fieldA >= 16'(REG_COUNT)) begin
          excCode_next = mbs_pkg::EXC_ADDRESS;
        end
      end
      mbs_pkg::FN_DIAG: begin
        if (rxCnt_reg != CW'(mbs_pkg::FIXED_LEN)) begin
          excCode_next = mbs_pkg::EXC_VALUE;
        end else if (fieldA != mbs_pkg::SUB_ECHO) begin
          excCode_next = mbs_pkg::EXC_FUNCTION;
        end
      end
      mbs_pkg::FN_FORCE_MULTI: begin
        if (fieldB == 16'h0000 || fieldB > 16'(NUM_RELAYS)) begin
          excCode_next = mbs_pkg::EXC_VALUE;
        end else if (17'(byteCount) != neededBytes
                     || 17'(rxCnt_reg) != 17'(mbs_pkg::FORCE_HDR_LEN) + 17'(byteCount)) begin
          excCode_next = mbs_pkg::EXC_VALUE;
        end else if (relayEnd > 17'(NUM_RELAYS)) begin
          excCode_next = mbs_pkg::EXC_ADDRESS;
        end
      end
      default: begin
        excCode_next = mbs_pkg::EXC_FUNCTION;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mbs_pkg::S_RX: begin
        if (rxEnd) begin
          state_next = mbs_pkg::S_CHECK;
        end
      end
      mbs_pkg::S_CHECK: begin
        state_next = frameOk ? mbs_pkg::S_EXEC : mbs_pkg::S_RX;
      end
      mbs_pkg::S_EXEC: begin
        state_next = mbs_pkg::S_SEND;
      end
      mbs_pkg::S_SEND: begin
        if (pushTake && txIdx_reg == respLen_reg - 1'b1) begin
          state_next = mbs_pkg::S_CRCL;
        end
      end
      mbs_pkg::S_CRCL: begin
        if (pushTake) begin
          state_next = mbs_pkg::S_CRCH;
        end
      end
      mbs_pkg::S_CRCH: begin
        if (pushTake) begin
          state_next = mbs_pkg::S_RX;
        end
      end
      default: begin
        state_next = mbs_pkg::S_RX;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= mbs_pkg::S_RX;
      rxReady_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      rxReady_reg <= (state_next == mbs_pkg::S_RX);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      excCode_reg <= mbs_pkg::EXC_NONE;
      respLen_reg <= '0;
    end else if (state_reg == mbs_pkg::S_CHECK && frameOk) begin
      excCode_reg <= excCode_next;
      respLen_reg <= (excCode_next != mbs_pkg::EXC_NONE) ? CW'(mbs_pkg::EXC_RSP_LEN)
                   : CW'(mbs_pkg::NORMAL_RSP_LEN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Store updates happen in S_EXEC, a cycle before the first answer byte
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        holdReg_reg[i] <= 16'h0000;
      end
    end else if (state_reg == mbs_pkg::S_EXEC && excCode_reg == mbs_pkg::EXC_NONE
                 && fnCode == mbs_pkg::FN_PRESET_ONE) begin
      holdReg_reg[fieldA[$clog2(REG_COUNT)-1:0]] <= fieldB;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      relayState_reg <= '0;
    end else if (state_reg == mbs_pkg::S_EXEC && excCode_reg == mbs_pkg::EXC_NONE
                 && fnCode == mbs_pkg::FN_FORCE_MULTI) begin
      for (int i = 0; i < NUM_RELAYS; i++) begin
        if (17'(i) >= 17'(fieldA) && 17'(i) < relayEnd) begin
          // Offset within the range picks byte and bit, LSB first
          relayState_reg[i] <= frameBuf[mbs_pkg::FORCE_DATA_POS + ((i - int'(fieldA)) >> 3)]
                                       [(i - int'(fieldA)) & 7];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Answer assembly; normal answers are the first six query bytes
  always_comb begin
    pushValid = 1'b0;
    pushData  = 8'h00;
    case (state_reg)
      mbs_pkg::S_SEND: begin
        pushValid = 1'b1;
        if (excCode_reg == mbs_pkg::EXC_NONE) begin
          pushData = frameBuf[txIdx_reg];
        end else if (txIdx_reg == CW'(1)) begin
          pushData = fnCode | mbs_pkg::EXC_FLAG;
        end else if (txIdx_reg == CW'(2)) begin
          pushData = excCode_reg;
        end else begin
          pushData = frameBuf[0];
        end
      end
      mbs_pkg::S_CRCL: begin
        pushValid = 1'b1;
        pushData  = txCrc_reg[7:0];
      end
      mbs_pkg::S_CRCH: begin
        pushValid = 1'b1;
        pushData  = txCrc_reg[15:8];
      end
      default: begin
        pushValid = 1'b0;
      end
    endcase
  end

  assign pushTake = pushValid && pushReady;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      txIdx_reg <= '0;
      txCrc_reg <= mbs_pkg::CRC_INIT;
    end else if (state_reg == mbs_pkg::S_EXEC) begin
      txIdx_reg <= '0;
      txCrc_reg <= mbs_pkg::CRC_INIT;
    end else if (state_reg == mbs_pkg::S_SEND && pushTake) begin
      txIdx_reg <= txIdx_reg + 1'b1;
      txCrc_reg <= mbs_pkg::crcStep(txCrc_reg, pushData);
    end
  end

  // A stalled link fills the queue, which in turn holds the answer assembly
  mbs_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_txFifo (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .inValid  (pushValid),
    .inData   (pushData),
    .inReady  (pushReady),
    .outValid (txValid),
    .outData  (txData),
    .outReady (txReady)
  );

  assign rxReady    = rxReady_reg;
  assign relayState = relayState_reg;
  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      holdRegs[i*16 +: 16] = holdReg_reg[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic inExecOk;
  assign inExecOk = (state_reg == mbs_pkg::S_EXEC) && (excCode_reg == mbs_pkg::EXC_NONE);

  property p_preset_write;
    inExecOk && fnCode == mbs_pkg::FN_PRESET_ONE
    |=> holdReg_reg[fieldA[$clog2(REG_COUNT)-1:0]] == {frameBuf[4], frameBuf[5]};
  endproperty
  a_preset_write: assert property (p_preset_write) else $error("preset value not stored");

  property p_echo_after_write;
    state_reg == mbs_pkg::S_SEND && txIdx_reg == '0
    |-> $past(state_reg) == mbs_pkg::S_EXEC || $past(state_reg) == mbs_pkg::S_SEND;
  endproperty
  a_echo_after_write: assert property (p_echo_after_write) else $error("answer began before store");

  property p_diag_codes;
    state_reg == mbs_pkg::S_SEND && excCode_reg == mbs_pkg::EXC_NONE && fnCode == mbs_pkg::FN_DIAG
    && txIdx_reg >= CW'(1) && txIdx_reg <= CW'(3) |-> pushData == frameBuf[txIdx_reg];
  endproperty
  a_diag_codes: assert property (p_diag_codes) else $error("diag codes not repeated");

  property p_loopback;
    state_reg == mbs_pkg::S_CHECK && frameOk && fnCode == mbs_pkg::FN_DIAG
    && fieldA == mbs_pkg::SUB_ECHO && rxCnt_reg == CW'(mbs_pkg::FIXED_LEN)
    |=> excCode_reg == mbs_pkg::EXC_NONE && respLen_reg == CW'(mbs_pkg::NORMAL_RSP_LEN);
  endproperty
  a_loopback: assert property (p_loopback) else $error("loop-back not answered in full");

  property p_relay_first;
    inExecOk && fnCode == mbs_pkg::FN_FORCE_MULTI
    |=> relayState_reg[fieldA[$clog2(NUM_RELAYS)-1:0]] == frameBuf[mbs_pkg::FORCE_DATA_POS][0];
  endproperty
  a_relay_first: assert property (p_relay_first) else $error("start relay wrong");

  property p_relay_second;
    inExecOk && fnCode == mbs_pkg::FN_FORCE_MULTI && fieldB >= 16'd2
    |=> relayState_reg[fieldA[$clog2(NUM_RELAYS)-1:0] + 1'b1] == frameBuf[mbs_pkg::FORCE_DATA_POS][1];
  endproperty
  a_relay_second: assert property (p_relay_second) else $error("bit order wrong");

  property p_too_many;
    state_reg == mbs_pkg::S_CHECK && frameOk && fnCode == mbs_pkg::FN_FORCE_MULTI
    && fieldB > 16'(NUM_RELAYS) |=> excCode_reg == mbs_pkg::EXC_VALUE;
  endproperty
  a_too_many: assert property (p_too_many) else $error("oversize force accepted");

  property p_force_len;
    state_reg == mbs_pkg::S_CHECK && frameOk && fnCode == mbs_pkg::FN_FORCE_MULTI
    && excCode_next == mbs_pkg::EXC_NONE |=> respLen_reg == CW'(mbs_pkg::NORMAL_RSP_LEN);
  endproperty
  a_force_len: assert property (p_force_len) else $error("force answer length wrong");

  property p_exc_flag;
    state_reg == mbs_pkg::S_SEND && excCode_reg != mbs_pkg::EXC_NONE && txIdx_reg == CW'(1)
    |-> pushData == (fnCode | 8'h80) ##0 pushData[7];
  endproperty
  a_exc_flag: assert property (p_exc_flag) else $error("exception flag missing");

  property p_drop_silent;
    state_reg == mbs_pkg::S_CHECK && !frameOk |=> state_reg == mbs_pkg::S_RX ##1 !pushValid;
  endproperty
  a_drop_silent: assert property (p_drop_silent) else $error("bad query not dropped");

  c_preset: cover property (inExecOk && fnCode == mbs_pkg::FN_PRESET_ONE);
  c_diag:   cover property (inExecOk && fnCode == mbs_pkg::FN_DIAG);
  c_force:  cover property (inExecOk && fnCode == mbs_pkg::FN_FORCE_MULTI);
  c_exc:    cover property (state_reg == mbs_pkg::S_EXEC && excCode_reg != mbs_pkg::EXC_NONE);
endmodule

// file: src/mbs_fifo.sv
`timescale 1ns/10ps
module mbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,  // Clock
  input  wire logic             nrst,     // Asynchronous reset, active low
  input  wire logic             inValid,  // Write side offers a word
  input  wire logic [WIDTH-1:0] inData,   // Word to store
  output logic                  inReady,  // Room for a word
  output logic                  outValid, // A word is waiting
  output logic      [WIDTH-1:0] outData,  // Oldest word
  input  wire logic             outReady  // Drain side takes the word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic             doWrite;
  logic             doRead;

  assign inReady  = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData  = mem[rdPtr_reg];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (doWrite) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule

// file: test/mbs_client_model.sv
`timescale 1ns/10ps
module mbs_client_model (
  input  wire logic       ref_clk,  // Clock
  input  wire logic       rxReady,  // Handler accepts query bytes
  output logic            rxValid,  // Query byte strobe
  output logic      [7:0] rxData,   // Query byte
  output logic            rxEnd,    // Frame end pulse
  input  wire logic       txValid,  // Response byte waiting
  input  wire logic [7:0] txData,   // Response byte
  output logic            txReady,  // Taking response bytes
  input  wire logic       slowSink  // Stall the response stream
);
  logic [7:0] rsp[$];
  logic [2:0] stallCnt = 3'h0;

  initial begin
    rxValid = 1'b0;
    rxData  = 8'h00;
    rxEnd   = 1'b0;
    txReady = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // A slow client takes one byte in eight, so the handler's FIFO backs up
  always @(negedge ref_clk) begin
    stallCnt <= stallCnt + 3'h1;
    txReady  <= !slowSink || (stallCnt == 3'h0);
  end

  always @(posedge ref_clk) begin
    if (txValid === 1'b1 && txReady === 1'b1) begin
      rsp.push_back(txData);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bytes go back to back; the end pulse rides with the last one
  task automatic sendFrame(input logic [7:0] q[$]);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (rxReady !== 1'b1 && n < 200);
    foreach (q[i]) begin
      rxValid = 1'b1;
      rxData  = q[i];
      rxEnd   = (i == q.size() - 1);
      @(negedge ref_clk);
    end
    rxValid = 1'b0;
    rxEnd   = 1'b0;
    // Released line shows junk, not the last byte
    rxData  = ~rxData;
  endtask
endmodule

// file: test/tb_top.sv
`timescale 1ns/10ps
`define CHK(name, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; $display("[FAIL] %s expected %h seen %h", name, exp, got); end end
module tb_top;
  typedef logic [7:0] mbs_bytes_t[$];
  localparam int REGS   = 16;
  localparam int RELAYS = 256;

  logic                ref_clk = 1'b0;
  logic                nrst;
  logic          [7:0] ownAddr;
  logic                slowSink;
  wire logic           rxValid;
  wire logic     [7:0] rxData;
  wire logic           rxEnd;
  wire logic           rxReady;
  wire logic           txValid;
  wire logic     [7:0] txData;
  wire logic           txReady;
  wire logic [RELAYS-1:0] relayState;
  wire logic [REGS*16-1:0] holdRegs;
  logic [RELAYS-1:0]   expRelays;
  logic [REGS*16-1:0]  expRegs;
  logic         [31:0] rngState = 32'h0000005b;
  mbs_bytes_t          none;
  int                  errors = 0;
  int                  checks = 0;

  always #4 ref_clk = ~ref_clk;

  mbs_handler #(.REG_COUNT(REGS), .NUM_RELAYS(RELAYS), .MAX_FRAME(48), .FIFO_DEPTH(16)) i_mbs_handler (
    .ref_clk(ref_clk), .nrst(nrst), .ownAddr(ownAddr), .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd),
    .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady), .relayState(relayState),
    .holdRegs(holdRegs));

  mbs_client_model i_mbs_client_model (
    .ref_clk(ref_clk), .rxReady(rxReady), .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd),
    .txValid(txValid), .txData(txData), .txReady(txReady), .slowSink(slowSink));

  ////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction

  // Own CRC so that a shared slip with the handler cannot hide
  function automatic mbs_bytes_t withCrc(input mbs_bytes_t q);
    logic [15:0] c;
    mbs_bytes_t r;
    c = 16'hffff;
    r = q;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    r.push_back(c[7:0]);
    r.push_back(c[15:8]);
    return r;
  endfunction

  task automatic print_verdict();
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic runQuery(input mbs_bytes_t q, input mbs_bytes_t exp, input logic corrupt);
    mbs_bytes_t f;
    int n;
    f = withCrc(q);
    if (corrupt) f[f.size()-1] ^= 8'h5a;
    i_mbs_client_model.rsp.delete();
    i_mbs_client_model.sendFrame(f);
    if (exp.size() > 0) begin
      exp = withCrc(exp);
      n = 0;
      while (txValid !== 1'b1 && n < 100) begin
        @(negedge ref_clk);
        n++;
      end
      `CHK("regsAtAnswer", expRegs, holdRegs)
      `CHK("relaysAtAnswer", expRelays, relayState)
    end
    n = 0;
    while (i_mbs_client_model.rsp.size() < exp.size() && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (30) @(negedge ref_clk);
    `CHK("rspLen", exp.size(), i_mbs_client_model.rsp.size())
    foreach (exp[i]) if (i < i_mbs_client_model.rsp.size()) `CHK("rspByte", exp[i], i_mbs_client_model.rsp[i])
    `CHK("relays", expRelays, relayState)
    `CHK("regs", expRegs, holdRegs)
    `CHK("rxReadyBack", 1'b1, rxReady)
  endtask

  task automatic doPreset(input logic [7:0] addr, input int a, input logic [15:0] v, input logic [7:0] code);
    mbs_bytes_t q;
    q = {addr, 8'h06, 8'(a >> 8), 8'(a), v[15:8], v[7:0]};
    if (code == 8'h00) begin
      expRegs[a*16 +: 16] = v;
      runQuery(q, q, 1'b0);
    end else
      runQuery(q, {addr, 8'h86, code}, 1'b0);
  endtask

  task automatic doDiag(input logic [15:0] sub, input logic [15:0] d, input logic [7:0] code);
    mbs_bytes_t q;
    q = {8'h11, 8'h08, sub[15:8], sub[7:0], d[15:8], d[7:0]};
    if (code == 8'h00)
      runQuery(q, q, 1'b0);
    else
      runQuery(q, {8'h11, 8'h88, code}, 1'b0);
  endtask

  task automatic doForce(input int s, input int n, input int bc, input logic [7:0] code, input int t);
    mbs_bytes_t q;
    logic [7:0] b;
    logic [31:0] r;
    q = {8'h11, 8'h0f, 8'(s >> 8), 8'(s), 8'(n >> 8), 8'(n), 8'(bc)};
    for (int i = 0; i < bc; i++) begin
      r = rnd();
      b = (t == 1) ? ((i == 0) ? 8'hcd : 8'h01) : r[7:0];
      for (int k = 0; k < 8; k++) if (i * 8 + k >= n) b[k] = 1'b0;
      q.push_back(b);
      for (int k = 0; k < 8; k++) if (code == 8'h00 && i * 8 + k < n) expRelays[s + i * 8 + k] = b[k];
    end
    if (code == 8'h00)
      runQuery(q, q[0:5], 1'b0);
    else
      runQuery(q, {8'h11, 8'h8f, code}, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    int a;
    int s;
    int n;
    nrst      = 1'b0;
    ownAddr   = 8'h11;
    slowSink  = 1'b0;
    expRelays = '0;
    expRegs   = '0;
    repeat (4) @(negedge ref_clk);
    `CHK("rstReady", 1'b0, rxReady)
    `CHK("rstValid", 1'b0, txValid)
    `CHK("rstRelays", expRelays, relayState)
    `CHK("rstRegs", expRegs, holdRegs)
    nrst = 1'b1;
    for (int t = 0; t < 12; t++) begin
      slowSink = t[0];
      r = rnd();
      a = (t == 0) ? REGS - 1 : (t == 1) ? 0 : int'(r[3:0]);
      doPreset(8'h11, a, r[31:16], 8'h00);
      r = rnd();
      doDiag(16'h0000, r[15:0], 8'h00);
      r = rnd();
      n = (t == 0) ? 256 : (t == 1) ? 10 : (t == 2) ? 1 : int'(r[4:0]) + 1;
      s = (t == 0) ? 0 : (t == 1) ? 15 : (t == 2) ? 255 : int'(r[15:8]) % (257 - n);
      doForce(s, n, (n + 7) / 8, 8'h00, t);
    end
    r = rnd();
    doPreset(8'h11, 2, r[15:0], 8'h00);
    // Dropped queries carry another value, so a stray write would show
    runQuery({8'h12, 8'h06, 8'h00, 8'h02, ~r[15:8], ~r[7:0]}, none, 1'b0);
    runQuery({8'h11, 8'h06, 8'h00, 8'h03, ~r[15:8], ~r[7:0]}, none, 1'b1);
    doPreset(8'h11, REGS, 16'h1234, 8'h02);
    doDiag(16'h0001, 16'ha537, 8'h01);
    doForce(0, 257, 33, 8'h03, 5);
    doForce(250, 10, 2, 8'h02, 5);
    doForce(0, 10, 1, 8'h03, 5);
    doForce(0, 0, 0, 8'h03, 5);
    runQuery({8'h11, 8'h03, 8'h00, 8'h6b, 8'h00, 8'h03}, {8'h11, 8'h83, 8'h01}, 1'b0);
    print_verdict();
  end

  initial begin
    #400000;
    errors++;
    print_verdict();
  end
endmodule
